// file: hw/octg_global_regs.sv
// Purpose: Global direct register bank of an eight-link E1 transceiver
// Assumes: APB slave, one wait state per access, synchronous reset
// Notes: Software reset spares only the line mode register
//
// Added by the designer: the APB interface to the registers.
module octg_global_regs #(
	parameter int unsigned TICK_PERIOD = 200000000,
	parameter int LINKS = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Per-link inputs
	input wire logic [LINKS-1:0] linkIrqFlag,
	input wire logic [LINKS-1:0] recClk,
	// Reference clock pins
	output logic firstRefClockPin,
	output logic secondRefClockPin,
	// Path watch routing toward link 1
	output logic watchActive,
	output logic watchTransmit,
	output logic [2:0] watchLink,
	// General pins
	input wire logic [1:0] gpioIn,
	output logic [1:0] gpioOut,
	output logic [1:0] gpioOe,
	// Device-wide controls
	output logic lineModeT1,
	output logic softResetPulse,
	output logic irqPin
);
	import octg_pkg::*;

	logic [9:0] idx;
	logic aligned;
	logic access;
	logic wrAcc;
	logic softHit;
	logic regRst;
	logic mapped;
	logic [7:0] rdData;
	logic [3:0] pathWatchSelect_q;
	logic [2:0] refAClockSource_q;
	logic [2:0] refBClockSource_q;
	logic secondTickIrqEnable_q;
	logic secondTickFlag_q;
	logic lineMode_q;
	logic tick;
	logic [1:0] gpioDir;
	logic [1:0] gpioLevel;
	logic [LINKS-1:0] irqSummary;

	// Decode: index is word address, low address bits must be zero
	assign idx = paddr[11:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign access = psel && penable && pready;
	assign wrAcc = access && pwrite && aligned;
	assign softHit = wrAcc && (idx == IDX_SOFT_RESET);
	// Software reset acts at the very write edge so no stale state lingers
	assign regRst = sys_rst || softHit;
	assign irqSummary = linkIrqFlag;

	always_comb begin
		case (idx)
			IDX_VERSION, IDX_SOFT_RESET, IDX_PATH_WATCH, IDX_GENERAL_PIN,
			IDX_REF_ROUTE, IDX_LINK_IRQ, IDX_TICK_CTRL, IDX_TICK_IND,
			IDX_LINE_MODE: mapped = aligned;
			default: mapped = 1'b0;
		endcase
	end

	// Read multiplexer; reserved bits and write-only words read zero
	always_comb begin
		rdData = 8'h00;
		case (idx)
			IDX_VERSION: rdData = VERSION_CODE;
			IDX_PATH_WATCH: rdData = {4'h0, pathWatchSelect_q};
			IDX_GENERAL_PIN: begin
				rdData = {4'h0, gpioLevel, gpioDir};
			end
			IDX_REF_ROUTE: begin
				rdData = {2'h0, refBClockSource_q, refAClockSource_q};
			end
			IDX_LINK_IRQ: rdData = 8'(irqSummary);
			IDX_TICK_CTRL: rdData = {7'h0, secondTickIrqEnable_q};
			IDX_TICK_IND: rdData = {7'h0, secondTickFlag_q};
			IDX_LINE_MODE: rdData = {7'h0, lineMode_q};
			default: rdData = 8'h00;
		endcase
	end

	// APB answer: one wait state, ready pulses for one cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !mapped;
			prdata <= (mapped && !pwrite) ? {24'h0, rdData} : 32'h0;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Path watch select
	always_ff @(posedge clk) begin
		if (regRst)
			pathWatchSelect_q <= WATCH_RST;
		else if (wrAcc && idx == IDX_PATH_WATCH)
			pathWatchSelect_q <= pwdata[3:0];
	end

	// Reference clock route select
	always_ff @(posedge clk) begin
		if (regRst) begin
			refAClockSource_q <= REF_ROUTE_RST[REF_A_LSB +: 3];
			refBClockSource_q <= REF_ROUTE_RST[REF_B_LSB +: 3];
		end else if (wrAcc && idx == IDX_REF_ROUTE) begin
			refAClockSource_q <= pwdata[REF_A_LSB +: 3];
			refBClockSource_q <= pwdata[REF_B_LSB +: 3];
		end
	end

	// Tick interrupt enable
	always_ff @(posedge clk) begin
		if (regRst)
			secondTickIrqEnable_q <= 1'b0;
		else if (wrAcc && idx == IDX_TICK_CTRL)
			secondTickIrqEnable_q <= pwdata[TICK_BIT];
	end

	// Tick flag: a tick in the clearing cycle wins over the clear
	always_ff @(posedge clk) begin
		if (regRst)
			secondTickFlag_q <= 1'b0;
		else if (tick)
			secondTickFlag_q <= 1'b1;
		else if (wrAcc && idx == IDX_TICK_IND && pwdata[TICK_BIT])
			secondTickFlag_q <= 1'b0;
	end

	// Line mode survives software reset; only the pin reset clears it
	always_ff @(posedge clk) begin
		if (sys_rst)
			lineMode_q <= LINE_MODE_RST;
		else if (wrAcc && idx == IDX_LINE_MODE)
			lineMode_q <= pwdata[0];
	end

	// Routed and registered outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			firstRefClockPin <= 1'b0;
			secondRefClockPin <= 1'b0;
			watchActive <= 1'b0;
			watchTransmit <= 1'b0;
			watchLink <= 3'h0;
			irqPin <= 1'b0;
			lineModeT1 <= 1'b0;
			softResetPulse <= 1'b0;
		end else begin
			firstRefClockPin <= recClk[refAClockSource_q];
			secondRefClockPin <= recClk[refBClockSource_q];
			watchActive <= (pathWatchSelect_q[2:0] != 3'h0);
			watchTransmit <= pathWatchSelect_q[WATCH_DIR_BIT];
			watchLink <= pathWatchSelect_q[2:0];
			irqPin <= (secondTickIrqEnable_q && secondTickFlag_q)
				|| (|irqSummary);
			lineModeT1 <= lineMode_q;
			softResetPulse <= softHit;
		end
	end

	// One-second timer
	octg_tick_timer #(
		.PERIOD(TICK_PERIOD)
	) uTimer (
		.clk(clk),
		.rst(regRst),
		.tick(tick)
	);

	// General-purpose pins
	octg_gpio #(
		.PINS(2)
	) uGpio (
		.clk(clk),
		.rst(regRst),
		.wrEn(wrAcc && idx == IDX_GENERAL_PIN),
		.wrDir(pwdata[GPIO_DIR_LSB +: 2]),
		.wrLevel(pwdata[GPIO_LEVEL_LSB +: 2]),
		.pinIn(gpioIn),
		.pinOut(gpioOut),
		.pinOe(gpioOe),
		.rdDir(gpioDir),
		.rdLevel(gpioLevel)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_version_fixed: assert property (access && !pwrite && idx == IDX_VERSION
		&& aligned |-> prdata == {24'h0, VERSION_CODE})
		else $error("version read wrong");
	a_soft_reset_pulse: assert property (softHit |=> softResetPulse
		&& pathWatchSelect_q == WATCH_RST && !secondTickFlag_q)
		else $error("soft reset not applied");
	a_mode_kept: assert property (softHit |=> lineMode_q == $past(lineMode_q))
		else $error("line mode lost on soft reset");
	a_watch_route: assert property (##1 watchTransmit ==
		$past(pathWatchSelect_q[3]) && watchActive ==
		($past(pathWatchSelect_q[2:0]) != 3'h0))
		else $error("watch routing wrong");
	a_dir_oe: assert property (##1 gpioOe == ~$past(gpioDir)
		|| $past(regRst))
		else $error("pin enable mismatch");
	a_ref_b_route: assert property (##1 secondRefClockPin ==
		$past(recClk[refBClockSource_q]))
		else $error("second ref clock misrouted");
	a_ref_a_route: assert property (##1 firstRefClockPin ==
		$past(recClk[refAClockSource_q]))
		else $error("first ref clock misrouted");
	a_tick_sets: assert property (tick && !softHit |=> secondTickFlag_q)
		else $error("tick did not set flag");
	a_flag_holds: assert property (secondTickFlag_q && !regRst && !(wrAcc
		&& idx == IDX_TICK_IND && pwdata[0]) |=> secondTickFlag_q)
		else $error("flag dropped without clear");
	a_irq_gate: assert property (!secondTickIrqEnable_q && irqSummary == '0
		&& !regRst |=> !irqPin) else $error("masked tick drove irq");
	a_ready_one: assert property (pready |=> !pready)
		else $error("ready held too long");

	c_tick_clear: cover property (secondTickFlag_q ##1 !secondTickFlag_q);
	c_soft_reset: cover property (softHit);
	c_gpio_out: cover property (gpioOe != 2'h0);
	c_irq_tick: cover property (irqPin && secondTickIrqEnable_q);
endmodule : octg_global_regs

// file: hw/octg_pkg.sv
// Purpose: Shared constants for the octal transceiver global register bank
// Assumes: 200 MHz system clock, APB with 32-bit data, word per register
// Notes: Printed offsets are word indices; byte address is index times four
package octg_pkg;
	// Register word indices
	localparam logic [9:0] IDX_VERSION = 10'h000;
	localparam logic [9:0] IDX_SOFT_RESET = 10'h004;
	localparam logic [9:0] IDX_PATH_WATCH = 10'h005;
	localparam logic [9:0] IDX_GENERAL_PIN = 10'h006;
	localparam logic [9:0] IDX_REF_ROUTE = 10'h007;
	localparam logic [9:0] IDX_LINK_IRQ = 10'h009;
	localparam logic [9:0] IDX_TICK_CTRL = 10'h00a;
	localparam logic [9:0] IDX_TICK_IND = 10'h00b;
	localparam logic [9:0] IDX_LINE_MODE = 10'h020;
	// Field positions
	localparam int GPIO_DIR_LSB = 0;
	localparam int GPIO_LEVEL_LSB = 2;
	localparam int REF_A_LSB = 0;
	localparam int REF_B_LSB = 3;
	localparam int WATCH_DIR_BIT = 3;
	localparam int TICK_BIT = 0;
	// Reset values
	localparam logic [3:0] WATCH_RST = 4'h0;
	localparam logic [1:0] GPIO_DIR_RST = 2'h3;
	localparam logic [1:0] GPIO_LEVEL_RST = 2'h0;
	localparam logic [5:0] REF_ROUTE_RST = 6'h00;
	localparam logic LINE_MODE_RST = 1'b0;
	// Version code: arbitrary neutral value
	localparam logic [7:0] VERSION_CODE = 8'h5a;
	// Timing: one second at the system clock rate
	localparam longint TICK_PERIOD_S = 1;
	localparam longint CLK_HZ = 200000000;
	localparam longint TICK_CYCLES = TICK_PERIOD_S * CLK_HZ;
endpackage : octg_pkg

// file: hw/octg_tick_timer.sv
// Purpose: Free-running one-second tick generator
// Assumes: Synchronous active-high reset
// Notes: Restarts the count on any reset, including a software reset
module octg_tick_timer #(
	parameter int unsigned PERIOD = 200000000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Tick output
	output logic tick
);
	import octg_pkg::*;

	logic [31:0] count_q;

	// Count up through the period and pulse on wrap
	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= 32'h0;
			tick <= 1'b0;
		end else if (count_q == 32'(PERIOD - 1)) begin
			count_q <= 32'h0;
			tick <= 1'b1;
		end else begin
			count_q <= count_q + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule : octg_tick_timer

// file: hw/octg_gpio.sv
// Purpose: Two general-purpose pins with direction and level bits
// Assumes: Pin inputs synchronous to clk
// Notes: Direction 1 means input; level reads back the sampled pin then
module octg_gpio #(
	parameter int PINS = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register write port
	input wire logic wrEn,
	input wire logic [PINS-1:0] wrDir,
	input wire logic [PINS-1:0] wrLevel,
	// Pin signals
	input wire logic [PINS-1:0] pinIn,
	output logic [PINS-1:0] pinOut,
	output logic [PINS-1:0] pinOe,
	// Register read view
	output logic [PINS-1:0] rdDir,
	output logic [PINS-1:0] rdLevel
);
	import octg_pkg::*;

	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : gPin
			logic dir_q;
			logic level_q;
			logic sample_q;
			logic drive_q;
			logic enable_q;
			// Direction and driven level
			always_ff @(posedge clk) begin
				if (rst) begin
					dir_q <= GPIO_DIR_RST[g];
					level_q <= GPIO_LEVEL_RST[g];
				end else if (wrEn) begin
					dir_q <= wrDir[g];
					// Level write only lands while the pin is an output
					if (!wrDir[g] && !dir_q)
						level_q <= wrLevel[g];
				end
			end
			// Sample the pin level every cycle
			always_ff @(posedge clk) begin
				if (rst)
					sample_q <= 1'b0;
				else
					sample_q <= pinIn[g];
			end
			// Per-pin flops keep each output bit to a single process
			always_ff @(posedge clk) begin
				if (rst) begin
					drive_q <= 1'b0;
					enable_q <= 1'b0;
				end else begin
					drive_q <= level_q;
					enable_q <= ~dir_q;
				end
			end
			assign pinOut[g] = drive_q;
			assign pinOe[g] = enable_q;
			assign rdDir[g] = dir_q;
			assign rdLevel[g] = dir_q ? sample_q : level_q;
		end
	endgenerate
endmodule : octg_gpio

// file: verification/tb_octal_transceiver_global_regs.sv
// Purpose: Self-checking bench for the global register bank
// Assumes: One APB wait state, tick period shortened to TICK cycles
// Notes: Each scenario task drives the bank and judges what comes back
module tb_octal_transceiver_global_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import octg_pkg::*;
	localparam int unsigned TICK = 200;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] linkIrqFlag, recClk;
	logic [1:0] gpioIn, gpioOut, gpioOe;
	logic firstRefClockPin, secondRefClockPin, watchActive, watchTransmit;
	logic [2:0] watchLink;
	logic lineModeT1, softResetPulse, irqPin;
	int errTotal = 0;
	int testsRun = 0;
	longint cyc = 0;

	octg_global_regs #(.TICK_PERIOD(TICK), .LINKS(8)) dut (
		.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .linkIrqFlag(linkIrqFlag),
		.recClk(recClk), .firstRefClockPin(firstRefClockPin),
		.secondRefClockPin(secondRefClockPin), .watchActive(watchActive),
		.watchTransmit(watchTransmit), .watchLink(watchLink),
		.gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
		.lineModeT1(lineModeT1), .softResetPulse(softResetPulse),
		.irqPin(irqPin));

	// Clock at 200 MHz, plus a cycle count for measuring tick spacing
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic completeRun;
		$display("Comparisons %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : completeRun

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			errTotal++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [9:0] idx,
		input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			chk("pready", 32'h1, 32'h0);
			completeRun();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input string what, input logic [9:0] idx,
		input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(what, exp, rd);
	endtask : rdchk

	// Registered outputs need a few edges to follow a register write
	task automatic settle;
		repeat (3) @(posedge clk);
	endtask : settle

	// Bounded wait for the interrupt pin; a miss ends the run
	task automatic waitIrq(output longint at);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (irqPin !== 1'b1 && n < TICK + 50);
		chk("tick irq", 32'h1, {31'h0, irqPin});
		if (irqPin !== 1'b1) completeRun();
		at = cyc;
	endtask : waitIrq

	task automatic t_reset;
		rdchk("tick flag rst", IDX_TICK_IND, 32'h0);
		rdchk("version", IDX_VERSION, {24'h0, VERSION_CODE});
		apb(1'b1, IDX_VERSION, 32'hff);
		rdchk("version kept", IDX_VERSION, {24'h0, VERSION_CODE});
		rdchk("watch rst", IDX_PATH_WATCH, 32'h0);
		rdchk("pins rst", IDX_GENERAL_PIN, 32'h3);
		chk("pin enable rst", 32'h0, {30'h0, gpioOe});
		rdchk("route rst", IDX_REF_ROUTE, 32'h0);
		rdchk("tick ctrl rst", IDX_TICK_CTRL, 32'h0);
		apb(1'b0, 10'h3ff, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		$display("Test reset values done");
	endtask : t_reset

	// Every watch code, with reserved bits set on each write
	task automatic t_watch;
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, IDX_PATH_WATCH, 32'(c) | 32'hf0);
			settle();
			chk("watch active", {31'h0, c[2:0] != 3'h0}, {31'h0, watchActive});
			chk("watch tx", {31'h0, c[3]}, {31'h0, watchTransmit});
			chk("watch link", 32'(c[2:0]), {29'h0, watchLink});
			rdchk("watch read", IDX_PATH_WATCH, 32'(c));
		end
		$display("Test path watch done");
	endtask : t_watch

	task automatic t_pins;
		gpioIn <= 2'b01;
		// A level write lands only once the pin is already an output
		apb(1'b1, IDX_GENERAL_PIN, 32'hf8);
		apb(1'b1, IDX_GENERAL_PIN, 32'hf8);
		settle();
		chk("pin enable", 32'h3, {30'h0, gpioOe});
		chk("pin drive", 32'h2, {30'h0, gpioOut});
		rdchk("pins out read", IDX_GENERAL_PIN, 32'h08);
		apb(1'b1, IDX_GENERAL_PIN, 32'h0f);
		settle();
		chk("pin input", 32'h0, {30'h0, gpioOe});
		rdchk("pins in read", IDX_GENERAL_PIN, 32'h07);
		gpioIn <= 2'b10;
		settle();
		rdchk("pins in flip", IDX_GENERAL_PIN, 32'h0b);
		$display("Test general pins done");
	endtask : t_pins

	// Both routes carry different codes so a swap is caught
	task automatic t_route;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, IDX_REF_ROUTE, 32'((7 - i) * 8 + i));
			recClk <= 8'h01 << i;
			settle();
			chk("first ref hi", 32'h1, {31'h0, firstRefClockPin});
			chk("second ref lo", 32'h0, {31'h0, secondRefClockPin});
			recClk <= ~(8'h01 << i);
			settle();
			chk("first ref lo", 32'h0, {31'h0, firstRefClockPin});
			chk("second ref hi", 32'h1, {31'h0, secondRefClockPin});
		end
		rdchk("route read", IDX_REF_ROUTE, 32'h07);
		$display("Test clock routing done");
	endtask : t_route

	task automatic t_summary;
		apb(1'b1, IDX_LINK_IRQ, 32'hff);
		for (int i = 0; i < 8; i++) begin
			linkIrqFlag <= 8'h01 << i;
			rdchk("link summary", IDX_LINK_IRQ, 32'h1 << i);
		end
		linkIrqFlag <= 8'h00;
		rdchk("summary clear", IDX_LINK_IRQ, 32'h0);
		$display("Test link summary done");
	endtask : t_summary

	task automatic t_tick;
		longint t0, t1;
		apb(1'b1, IDX_TICK_CTRL, 32'hff);
		rdchk("tick ctrl", IDX_TICK_CTRL, 32'h1);
		// Flag has long been set by now; clear it so t0 marks a real tick
		apb(1'b1, IDX_TICK_IND, 32'h1);
		settle();
		waitIrq(t0);
		apb(1'b1, IDX_TICK_IND, 32'hfe);
		rdchk("flag kept", IDX_TICK_IND, 32'h1);
		apb(1'b1, IDX_TICK_IND, 32'h1);
		rdchk("flag cleared", IDX_TICK_IND, 32'h0);
		chk("irq after clear", 32'h0, {31'h0, irqPin});
		waitIrq(t1);
		chk("tick spacing", TICK, 32'(t1 - t0));
		apb(1'b1, IDX_TICK_IND, 32'h1);
		apb(1'b1, IDX_TICK_CTRL, 32'h0);
		repeat (TICK + 10) @(posedge clk);
		chk("irq masked", 32'h0, {31'h0, irqPin});
		rdchk("flag stays", IDX_TICK_IND, 32'h1);
		$display("Test second tick done");
	endtask : t_tick

	task automatic t_soft;
		int n;
		apb(1'b1, IDX_LINE_MODE, 32'h1);
		apb(1'b1, IDX_PATH_WATCH, 32'h9);
		apb(1'b1, IDX_GENERAL_PIN, 32'h0);
		apb(1'b1, IDX_TICK_CTRL, 32'h1);
		apb(1'b1, IDX_SOFT_RESET, 32'h0);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (softResetPulse !== 1'b1 && n < 3);
		chk("soft pulse", 32'h1, {31'h0, softResetPulse});
		rdchk("mode kept", IDX_LINE_MODE, 32'h1);
		chk("mode pin", 32'h1, {31'h0, lineModeT1});
		rdchk("watch back", IDX_PATH_WATCH, 32'h0);
		rdchk("tick ctrl back", IDX_TICK_CTRL, 32'h0);
		chk("pins back", 32'h0, {30'h0, gpioOe});
		$display("Test soft reset done");
	endtask : t_soft

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		linkIrqFlag = 8'h00;
		recClk = 8'h00;
		gpioIn = 2'b00;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_watch();
		t_pins();
		t_route();
		t_summary();
		t_tick();
		t_soft();
		completeRun();
	end
endmodule : tb_octal_transceiver_global_regs
